// ### rtl/awg_pkg.sv
// Constants and types for the converter register wait generator.
package awg_pkg;
  // Register select codes presented by the CPU with each access.
  localparam logic [1:0] SEL_MODE = 2'h0;
  localparam logic [1:0] SEL_CHANNEL = 2'h1;
  localparam logic [1:0] SEL_PORT_CFG = 2'h2;
  localparam logic [1:0] SEL_RESULT = 2'h3;

  // Conversion clock divider select codes (peripheral clock divided by N).
  localparam logic [2:0] DIV_SEL_2 = 3'h0;
  localparam logic [2:0] DIV_SEL_3 = 3'h1;
  localparam logic [2:0] DIV_SEL_4 = 3'h2;
  localparam logic [2:0] DIV_SEL_6 = 3'h3;
  localparam logic [2:0] DIV_SEL_8 = 3'h4;
  localparam logic [2:0] DIV_SEL_12 = 3'h5;

  // Divider ratios.
  localparam logic [7:0] DIV_2 = 8'h02;
  localparam logic [7:0] DIV_3 = 8'h03;
  localparam logic [7:0] DIV_4 = 8'h04;
  localparam logic [7:0] DIV_6 = 8'h06;
  localparam logic [7:0] DIV_8 = 8'h08;
  localparam logic [7:0] DIV_12 = 8'h0c;

  // Wait count formula terms and bounds.
  localparam logic [7:0] WAIT_MUL = 8'h02;
  localparam logic [7:0] WAIT_ADD = 8'h01;
  localparam logic [4:0] WAIT_MIN_FAST = 5'h01;
  localparam logic [4:0] WAIT_MIN_SLOW = 5'h02;
  localparam logic [1:0] EDGES_DONE = 2'h2;

  // Reset values.
  localparam logic [4:0] COUNT_RST = 5'h00;
  localparam logic [4:0] LIMIT_RST = 5'h01;
  localparam logic [1:0] EDGES_RST = 2'h0;

  typedef enum logic [1:0] {
    AWG_IDLE = 2'b00,
    AWG_WAIT = 2'b01,
    AWG_DONE = 2'b11
  } awg_state_type;

  typedef struct packed {
    awg_state_type st;
    logic [4:0] count;
    logic [4:0] limit;
    logic [1:0] edges;
    logic sync1;
    logic sync2;
    logic sync3;
    logic cpu_wait;
    logic done;
    logic periph_access;
    logic periph_write;
    logic [1:0] periph_sel;
    logic violation;
  } awg_regs_type;
endpackage

// ### rtl/awg_wait_gen.sv
// Wait-state generator for CPU accesses to the converter registers.
`timescale 1ns/1ps
`default_nettype none

module awg_wait_gen
  import awg_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire logic i_bus_req,
  input wire logic i_bus_write,
  input wire logic [1:0] i_bus_sel,
  input wire logic [2:0] i_conv_div_sel,
  input wire logic [1:0] i_cpu_shift,
  input wire logic i_prs_clk_run,
  input wire logic i_conv_clk,
  output logic o_cpu_wait,
  output logic o_access_done,
  output logic o_periph_access,
  output logic o_periph_write,
  output logic [1:0] o_periph_sel,
  output logic o_stopped_access
);

  awg_regs_type r_reg;
  awg_regs_type r_next;

  // The CPU clock is taken as the peripheral clock shifted right by
  // i_cpu_shift, which only holds when both come from one source.
  function automatic logic [4:0] calc_limit(input logic [2:0] div_sel,
                                            input logic [1:0] shift);
    logic [7:0] div;
    logic [7:0] num;
    logic [7:0] quo;
    logic [7:0] rem;
    logic [7:0] half_den;
    logic [7:0] total;
    div = DIV_2;
    case (div_sel)
      DIV_SEL_2: div = DIV_2;
      DIV_SEL_3: div = DIV_3;
      DIV_SEL_4: div = DIV_4;
      DIV_SEL_6: div = DIV_6;
      DIV_SEL_8: div = DIV_8;
      DIV_SEL_12: div = DIV_12;
      default: div = DIV_2;
    endcase
    num = 8'(WAIT_MUL * div);
    quo = num >> shift;
    rem = num - 8'(quo << shift);
    half_den = 8'(8'h01 << shift);
    total = quo + WAIT_ADD;
    if (8'(rem << 1) > half_den) begin
      total = total + 8'h01;
    end
    if (div >= DIV_6 && total < 8'(WAIT_MIN_SLOW)) begin
      total = 8'(WAIT_MIN_SLOW);
    end
    if (total < 8'(WAIT_MIN_FAST)) begin
      total = 8'(WAIT_MIN_FAST);
    end
    return total[4:0];
  endfunction

  function automatic logic is_wait_access(input logic wr, input logic [1:0] sel);
    return (wr && (sel == SEL_MODE || sel == SEL_CHANNEL || sel == SEL_PORT_CFG)) ||
           (!wr && sel == SEL_RESULT);
  endfunction

  logic conv_rise;
  logic finish;
  assign conv_rise = r_reg.sync2 && !r_reg.sync3;
  // Completion is confirmed by two conversion clock edges; the limit caps
  // the wait so a stalled peripheral clock cannot hang the CPU forever.
  assign finish = (r_reg.edges + {1'b0, conv_rise} >= EDGES_DONE) ||
                  (r_reg.count + 5'h01 >= r_reg.limit);

  always_comb begin
    r_next = r_reg;
    // Two flops settle the foreign conversion clock; the third only marks its rising edge.
    r_next.sync1 = i_conv_clk;
    r_next.sync2 = r_reg.sync1;
    r_next.sync3 = r_reg.sync2;
    r_next.done = 1'b0;
    case (r_reg.st)
      AWG_IDLE: begin
        if (i_bus_req) begin
          r_next.periph_write = i_bus_write;
          r_next.periph_sel = i_bus_sel;
          r_next.count = COUNT_RST;
          r_next.edges = EDGES_RST;
          r_next.limit = calc_limit(i_conv_div_sel, i_cpu_shift);
          if (is_wait_access(i_bus_write, i_bus_sel)) begin
            r_next.st = AWG_WAIT;
            r_next.cpu_wait = 1'b1;
            r_next.periph_access = 1'b1;
            // A stopped peripheral clock here is a software fault; flag it.
            r_next.violation = !i_prs_clk_run;
          end else begin
            r_next.st = AWG_DONE;
            r_next.done = 1'b1;
            r_next.periph_access = 1'b1;
          end
        end
      end
      AWG_WAIT: begin
        r_next.count = r_reg.count + 5'h01;
        if (conv_rise) begin
          r_next.edges = r_reg.edges + 2'h1;
        end
        if (finish) begin
          r_next.st = AWG_DONE;
          r_next.cpu_wait = 1'b0;
          r_next.done = 1'b1;
          r_next.periph_access = 1'b0;
        end else begin
          r_next.periph_access = 1'b1;
        end
      end
      AWG_DONE: begin
        // One dead cycle while the done pulse is high, so a request held over from the
        // finished access cannot be taken a second time.
        r_next.st = AWG_IDLE;
        r_next.periph_access = 1'b0;
        r_next.violation = 1'b0;
      end
      default: begin
        r_next.st = AWG_IDLE;
        r_next.cpu_wait = 1'b0;
        r_next.periph_access = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      r_reg.st <= AWG_IDLE;
      r_reg.count <= COUNT_RST;
      r_reg.limit <= LIMIT_RST;
      r_reg.edges <= EDGES_RST;
      r_reg.sync1 <= 1'b0;
      r_reg.sync2 <= 1'b0;
      r_reg.sync3 <= 1'b0;
      r_reg.cpu_wait <= 1'b0;
      r_reg.done <= 1'b0;
      r_reg.periph_access <= 1'b0;
      r_reg.periph_write <= 1'b0;
      r_reg.periph_sel <= SEL_MODE;
      r_reg.violation <= 1'b0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign o_cpu_wait = r_reg.cpu_wait;
  assign o_access_done = r_reg.done;
  assign o_periph_access = r_reg.periph_access;
  assign o_periph_write = r_reg.periph_write;
  assign o_periph_sel = r_reg.periph_sel;
  assign o_stopped_access = r_reg.violation;

  chk_wait_on_conv: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (r_reg.st == AWG_IDLE && i_bus_req && is_wait_access(i_bus_write, i_bus_sel))
    |=> o_cpu_wait && !o_access_done)
    else $error("no wait on converter register access");

  chk_no_wait_other: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (r_reg.st == AWG_IDLE && i_bus_req && !is_wait_access(i_bus_write, i_bus_sel))
    |=> !o_cpu_wait && o_access_done)
    else $error("wait raised on a non-waiting access");

  chk_wait_bound: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    o_cpu_wait |-> r_reg.count < r_reg.limit)
    else $error("wait ran past its computed limit");

  chk_release_next: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (r_reg.st == AWG_WAIT && finish) |=> !o_cpu_wait && o_access_done ##1 !o_access_done)
    else $error("wait not released one cycle after completion");

  chk_access_held: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    o_cpu_wait |-> o_periph_access)
    else $error("peripheral access dropped while CPU waits");

  chk_target_held: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    o_cpu_wait && $past(o_cpu_wait) |-> $stable(o_periph_sel) && $stable(o_periph_write))
    else $error("peripheral target changed while CPU waits");

  chk_count_cpu: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (o_cpu_wait && $past(o_cpu_wait)) |-> r_reg.count == $past(r_reg.count) + 5'h01)
    else $error("wait counter did not advance on the CPU clock");

  chk_limit_slow: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    $rose(o_cpu_wait) && $past(i_conv_div_sel) >= DIV_SEL_6 &&
    $past(i_conv_div_sel) <= DIV_SEL_12 |-> r_reg.limit >= WAIT_MIN_SLOW)
    else $error("slow divider limit below two clocks");

  chk_limit_max: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    $rose(o_cpu_wait) && $past(i_conv_div_sel) == DIV_SEL_2 && $past(i_cpu_shift) == 2'h0
    |-> r_reg.limit == 5'h05)
    else $error("limit wrong for divide by two at full CPU speed");

  chk_stop_flag: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (r_reg.st == AWG_IDLE && i_bus_req && is_wait_access(i_bus_write, i_bus_sel)
     && !i_prs_clk_run) |=> o_stopped_access)
    else $error("access with stopped peripheral clock not flagged");

endmodule

`default_nettype wire

// ### sim/awg_cpu_model.sv
// CPU model that issues single register accesses and counts wait cycles.
`timescale 1ns/1ps
`default_nettype none
module awg_cpu_model (
  input wire logic i_mclk,
  input wire logic i_cpu_wait,
  input wire logic i_access_done,
  input wire logic i_periph_access,
  input wire logic i_periph_write,
  input wire logic [1:0] i_periph_sel,
  output logic o_bus_req,
  output logic o_bus_write,
  output logic [1:0] o_bus_sel
);
  initial begin
    o_bus_req = 1'b0;
    o_bus_write = 1'b0;
    o_bus_sel = 2'h0;
  end

  // Only one access in flight at a time.
  task automatic access(input logic w, input logic [1:0] s, output int waits, output logic ok);
    waits = 0;
    ok = 1'b1;
    @(posedge i_mclk);
    o_bus_req <= 1'b1;
    o_bus_write <= w;
    o_bus_sel <= s;
    @(posedge i_mclk);
    o_bus_req <= 1'b0;
    // Released qualifiers show the inverse so a stale sample cannot pass.
    o_bus_write <= ~w;
    o_bus_sel <= ~s;
    for (int i = 0; i < 40; i++) begin
      #1;
      if (i_access_done === 1'b1) break;
      if (i_cpu_wait === 1'b1) waits++;
      if (i_cpu_wait !== i_periph_access) ok = 1'b0;
      if (i_cpu_wait && {i_periph_write, i_periph_sel} !== {w, s}) ok = 1'b0;
      @(posedge i_mclk);
    end
    ok = ok && (i_access_done === 1'b1);
  endtask
endmodule
`default_nettype wire

// ### sim/testbench.sv
// Self-checking bench for the converter register wait generator.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import awg_pkg::*;
  logic i_mclk = 1'b0;
  logic i_rstn = 1'b0;
  logic i_conv_clk = 1'b0;
  logic [2:0] div_sel = 3'h0;
  logic [1:0] shift = 2'h0;
  logic req, wr, cpu_wait, done, pacc;
  logic [1:0] sel, psel;
  logic pwr, stop;
  logic prs_run = 1'b1;
  bit conv_run = 1'b0;
  int num_errors = 0;
  int compares = 0;
  int divs[6] = '{2, 3, 4, 6, 8, 12};
  int d, sh;

  always #25 i_mclk = ~i_mclk;
  always @(posedge i_mclk) if (conv_run) i_conv_clk <= 1'($urandom_range(1, 0));

  awg_wait_gen dut (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_bus_req(req), .i_bus_write(wr),
    .i_bus_sel(sel), .i_conv_div_sel(div_sel), .i_cpu_shift(shift), .i_prs_clk_run(prs_run),
    .i_conv_clk(i_conv_clk), .o_cpu_wait(cpu_wait), .o_access_done(done),
    .o_periph_access(pacc), .o_periph_write(pwr), .o_periph_sel(psel),
    .o_stopped_access(stop));
  awg_cpu_model cpu (.i_mclk(i_mclk), .i_cpu_wait(cpu_wait), .i_access_done(done),
    .i_periph_access(pacc), .i_periph_write(pwr), .i_periph_sel(psel), .o_bus_req(req),
    .o_bus_write(wr), .o_bus_sel(sel));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: seen %0d expected %0d", $time, seen, exp);
    end
  endtask

  function automatic int exp_limit(input int div, input int s);
    real x;
    int q;
    x = 2.0 * div / (1 << s);
    q = $rtoi(x);
    if (x - q > 0.5) q++;
    q++;
    if (div >= 6 && q < 2) q = 2;
    return q;
  endfunction

  task automatic run_access(input logic w, input logic [1:0] s, input bit exact);
    int waits;
    int lim;
    logic ok;
    bit wt;
    lim = exp_limit(divs[d], sh);
    wt = (w && s != SEL_RESULT) || (!w && s == SEL_RESULT);
    cpu.access(w, s, waits, ok);
    check(ok, 1);
    check(stop, wt && !prs_run);
    if (wt) begin
      if (exact) check(waits, lim);
      else check(waits >= (divs[d] >= 6 ? 2 : 1) && waits <= lim, 1);
    end else begin
      check(waits, 0);
    end
  endtask

  task automatic finish_test();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    #1000000;
    num_errors++;
    finish_test();
  end

  initial begin
    void'($urandom(32'h3141));
    repeat (4) @(posedge i_mclk);
    i_rstn <= 1'b1;
    // With the conversion clock still, every wait runs to its full limit.
    for (d = 0; d < 6; d++) begin
      for (sh = 0; sh < 4; sh++) begin
        @(posedge i_mclk);
        div_sel <= 3'(d);
        shift <= 2'(sh);
        for (int k = 0; k < 8; k++) run_access(k[2], 2'(k), 1'b1);
      end
    end
    $display("test exact wait lengths done");
    conv_run = 1'b1;
    repeat (60) begin
      d = $urandom_range(5, 0);
      sh = $urandom_range(3, 0);
      @(posedge i_mclk);
      div_sel <= 3'(d);
      shift <= 2'(sh);
      run_access(1'($urandom_range(1, 0)), 2'($urandom_range(3, 0)), 1'b0);
    end
    $display("test random traffic done");
    // Misuse corner: a waiting access with the peripheral clock stopped must be flagged.
    @(posedge i_mclk);
    prs_run <= 1'b0;
    run_access(1'b1, SEL_MODE, 1'b0);
    run_access(1'b1, SEL_RESULT, 1'b0);
    @(posedge i_mclk);
    prs_run <= 1'b1;
    run_access(1'b0, SEL_RESULT, 1'b0);
    $display("test stopped clock flag done");
    finish_test();
  end
endmodule
`default_nettype wire
